// file: design/dlh_descriptor_list_handler.sv
// Descriptor list walker with register bus and interrupt
`timescale 1ns/1ps
`default_nettype none
module dlh_descriptor_list_handler
  import dlh_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Host memory master
  output dlh_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Fragment data path
  output dlh_frag_t frag,
  input wire logic frag_done,
  input wire dlh_frag_result_t frag_result,
  // Interrupt
  output logic irq
);

  dlh_state_t state;
  logic tx_run;
  logic rx_run;
  logic legacy_layout_enable;
  logic [31:0] tx_ptr;
  logic [31:0] rx_ptr;
  logic [31:0] desc_base;
  logic [31:0] link_reg;
  logic cur_rx;
  dlh_cmdsts_t cmd;
  dlh_cmdsts_t rd_cmd;
  dlh_cmdsts_t next_cmd;
  logic owned;
  logic stop_now;
  logic adv_now;
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] isr;
  logic [EVT_W-1:0] imr;
  logic wr_ctrl;
  logic wr_txdp;
  logic wr_rxdp;
  logic wr_isr;
  logic wr_imr;

  // Register write decode
  always_comb begin
    wr_ctrl = reg_wr && (reg_addr == OFF_CTRL);
    wr_txdp = reg_wr && (reg_addr == OFF_TXDP);
    wr_rxdp = reg_wr && (reg_addr == OFF_RXDP);
    wr_isr = reg_wr && (reg_addr == OFF_ISR);
    wr_imr = reg_wr && (reg_addr == OFF_IMR);
  end

  // Ownership test and list progress
  always_comb begin
    rd_cmd = dlh_cmdsts_t'(mem_rdata);
    // Device consumes transmit (own=1) and produces receive (own=0)
    owned = cur_rx ? !rd_cmd.own : rd_cmd.own;
    stop_now = (state == ST_RD_CMD) && mem_ack && !owned;
    adv_now = (state == ST_WR_CMD) && mem_ack;
  end

  // Write-back word returned to the list
  always_comb begin
    next_cmd = cmd;
    if (cur_rx) begin
      next_cmd.own = 1'b1;
      next_cmd.more = !frag_result.last;
      next_cmd.fcs = 1'b1;
      next_cmd.size = frag_result.size;
      next_cmd.status = frag_result.last ? frag_result.status
                                          : STATUS_NONE;
    end else begin
      next_cmd.own = 1'b0;
      next_cmd.status = cmd.more ? STATUS_NONE
                                 : frag_result.status;
    end
  end

  // Run bits; software start wins over a hardware stop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_run <= 1'b0;
    end else if (wr_ctrl && reg_wdata[CTRL_TX_RUN]) begin
      tx_run <= 1'b1;
    end else if (stop_now && !cur_rx) begin
      tx_run <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_run <= 1'b0;
    end else if (wr_ctrl && reg_wdata[CTRL_RX_RUN]) begin
      rx_run <= 1'b1;
    end else if (stop_now && cur_rx) begin
      rx_run <= 1'b0;
    end
  end

  // Layout select
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      legacy_layout_enable <= 1'b0;
    end else if (wr_ctrl) begin
      legacy_layout_enable <= reg_wdata[CTRL_LEGACY];
    end
  end

  // List pointers; hardware advance has priority
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ptr <= PTR_RESET;
    end else if (adv_now && !cur_rx) begin
      tx_ptr <= link_reg;
    end else if (wr_txdp && !tx_run) begin
      tx_ptr <= {reg_wdata[31:2], 2'b00};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ptr <= PTR_RESET;
    end else if (adv_now && cur_rx) begin
      rx_ptr <= link_reg;
    end else if (wr_rxdp && !rx_run) begin
      rx_ptr <= {reg_wdata[31:2], 2'b00};
    end
  end

  // Walker sequencing, one descriptor at a time
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cur_rx <= 1'b0;
      desc_base <= PTR_RESET;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // Same fetch sequence serves both lists
          if (tx_run) begin
            cur_rx <= 1'b0;
            desc_base <= tx_ptr;
            state <= ST_RD_LINK;
          end else if (rx_run) begin
            cur_rx <= 1'b1;
            desc_base <= rx_ptr;
            state <= ST_RD_LINK;
          end
        end
        ST_RD_LINK: begin
          if (mem_ack) begin
            state <= ST_RD_CMD;
          end
        end
        ST_RD_CMD: begin
          if (mem_ack) begin
            state <= owned ? ST_RD_BUF : ST_IDLE;
          end
        end
        ST_RD_BUF: begin
          if (mem_ack) begin
            state <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (frag_done) begin
            state <= ST_WR_CMD;
          end
        end
        ST_WR_CMD: begin
          if (mem_ack) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Link and command words of the current descriptor
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_reg <= PTR_RESET;
      cmd <= '0;
    end else if (state == ST_RD_LINK && mem_ack) begin
      link_reg <= {mem_rdata[31:2], 2'b00};
    end else if (state == ST_RD_CMD && mem_ack) begin
      cmd <= rd_cmd;
    end else if (state == ST_XFER && frag_done) begin
      cmd <= next_cmd;
    end
  end

  // Host memory request, held until acknowledged
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (tx_run || rx_run) begin
            mem_req.req <= 1'b1;
            mem_req.we <= 1'b0;
            mem_req.addr <= (tx_run ? tx_ptr : rx_ptr) + DESC_LINK;
          end
        end
        ST_RD_LINK: begin
          if (mem_ack) begin
            mem_req.addr <= desc_base + DESC_CMDSTS;
          end
        end
        ST_RD_CMD: begin
          if (mem_ack && owned) begin
            // Count word at 08h is never read in legacy layout
            mem_req.addr <= desc_base + (legacy_layout_enable
              ? DESC_BUF_LEGACY : DESC_BUF);
          end else if (mem_ack) begin
            mem_req.req <= 1'b0;
          end
        end
        ST_RD_BUF: begin
          if (mem_ack) begin
            mem_req.req <= 1'b0;
          end
        end
        ST_XFER: begin
          if (frag_done) begin
            mem_req.req <= 1'b1;
            mem_req.we <= 1'b1;
            mem_req.addr <= desc_base + DESC_CMDSTS;
            mem_req.wdata <= next_cmd;
          end
        end
        ST_WR_CMD: begin
          if (mem_ack) begin
            mem_req.req <= 1'b0;
            mem_req.we <= 1'b0;
          end
        end
        default: begin
          mem_req <= '0;
        end
      endcase
    end
  end

  // Fragment handed to the data path
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frag <= '0;
    end else if (state == ST_RD_BUF && mem_ack) begin
      // One fragment per descriptor
      frag.valid <= 1'b1;
      frag.is_rx <= cur_rx;
      // Transmit keeps byte offset; receive assumed word aligned
      frag.addr <= cur_rx ? {mem_rdata[31:2], 2'b00}
                          : mem_rdata;
      frag.count <= cmd.size;
      frag.omit_fcs_flag <= !cur_rx && cmd.fcs;
      frag.fcs_included_flag <= cur_rx;
    end else if (state != ST_XFER || frag_done) begin
      frag.valid <= 1'b0;
    end
  end

  // Event pulses into the sticky status
  always_comb begin
    evt = EVT_RESET;
    evt[EVT_TX_DESC] = adv_now && !cur_rx && cmd.completion_irq_request;
    evt[EVT_RX_DESC] = adv_now && cur_rx && cmd.completion_irq_request;
    evt[EVT_TX_IDLE] = stop_now && !cur_rx;
    evt[EVT_RX_IDLE] = stop_now && cur_rx;
  end

  dlh_event_irq #(
    .N(EVT_W)
  ) u_irq (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .evt(evt),
    .wr_status(wr_isr),
    .wr_mask(wr_imr),
    .wdata(reg_wdata[EVT_W-1:0]),
    .status(isr),
    .mask(imr),
    .irq(irq)
  );

  // Read data, valid only the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFF_CTRL: begin
          reg_rdata <= {29'h000_0000, legacy_layout_enable, rx_run, tx_run};
        end
        OFF_STAT: begin
          reg_rdata <= {25'h000_0000, cur_rx, state};
        end
        OFF_TXDP: begin
          reg_rdata <= tx_ptr;
        end
        OFF_RXDP: begin
          reg_rdata <= rx_ptr;
        end
        OFF_ISR: begin
          reg_rdata <= {28'h000_0000, isr};
        end
        OFF_IMR: begin
          reg_rdata <= {28'h000_0000, imr};
        end
        default: begin
          reg_rdata <= 32'h0000_0000;
        end
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : dlh_descriptor_list_handler
`default_nettype wire

// file: design/dlh_pkg.sv
// Constants and carrier types shared by the descriptor list handler
package dlh_pkg;

  // Register bus offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_TXDP = 8'h08;
  localparam logic [7:0] OFF_RXDP = 8'h0C;
  localparam logic [7:0] OFF_ISR = 8'h10;
  localparam logic [7:0] OFF_IMR = 8'h14;

  // Control register fields
  localparam int CTRL_TX_RUN = 0;
  localparam int CTRL_RX_RUN = 1;
  localparam int CTRL_LEGACY = 2;

  // Event bits of status and mask registers
  localparam int EVT_W = 4;
  localparam int EVT_TX_DESC = 0;
  localparam int EVT_RX_DESC = 1;
  localparam int EVT_TX_IDLE = 2;
  localparam int EVT_RX_IDLE = 3;

  // Descriptor word offsets, byte units
  localparam logic [31:0] DESC_LINK = 32'h0000_0000;
  localparam logic [31:0] DESC_CMDSTS = 32'h0000_0004;
  localparam logic [31:0] DESC_BUF = 32'h0000_0008;
  localparam logic [31:0] DESC_BUF_LEGACY = 32'h0000_000C;

  // Reset values
  localparam logic [31:0] PTR_RESET = 32'h0000_0000;
  localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;
  localparam logic [11:0] STATUS_NONE = 12'h000;

  // Command and status word, same for transmit and receive
  typedef struct packed {
    logic own;
    logic more;
    logic completion_irq_request;
    logic fcs;
    logic [11:0] status;
    logic [15:0] size;
  } dlh_cmdsts_t;

  // Bus master request towards host memory
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dlh_mem_req_t;

  // Fragment handed to the data path
  typedef struct packed {
    logic valid;
    logic is_rx;
    logic [31:0] addr;
    logic [15:0] count;
    logic omit_fcs_flag;
    logic fcs_included_flag;
  } dlh_frag_t;

  // Data path answer for a finished fragment
  typedef struct packed {
    logic last;
    logic [11:0] status;
    logic [15:0] size;
  } dlh_frag_result_t;

  // Walker states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_RD_LINK = 6'b00_0010,
    ST_RD_CMD = 6'b00_0100,
    ST_RD_BUF = 6'b00_1000,
    ST_XFER = 6'b01_0000,
    ST_WR_CMD = 6'b10_0000
  } dlh_state_t;

endpackage : dlh_pkg

// file: design/dlh_event_irq.sv
// Sticky event status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module dlh_event_irq #(
  parameter int N = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Events and software access
  input wire logic [N-1:0] evt,
  input wire logic wr_status,
  input wire logic wr_mask,
  input wire logic [N-1:0] wdata,
  // State and interrupt
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);

  logic [N-1:0] next_status;
  logic [N-1:0] next_mask;

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    next_status = (status & ~(wr_status ? wdata : '0)) | evt;
    next_mask = wr_mask ? wdata : mask;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
      mask <= '0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      irq <= |(next_status & next_mask);
    end
  end

endmodule : dlh_event_irq
`default_nettype wire

// file: test/dlh_host_mem.sv
// Host memory model answering the descriptor walker
`timescale 1ns/1ps
`default_nettype none
module dlh_host_mem
  import dlh_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Request and answer
  input wire dlh_mem_req_t mem_req,
  input wire logic [1:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:63];
  logic [1:0] cnt;
  // Answer after lat waits; data lines toggle outside an answer
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      mem_rdata <= 32'h0000_0000;
    end else if (mem_req.req && !mem_ack && cnt >= lat) begin
      mem_ack <= 1'b1;
      cnt <= 2'h0;
      if (mem_req.we) mem[mem_req.addr[7:2]] <= mem_req.wdata;
      else mem_rdata <= mem[mem_req.addr[7:2]];
    end else begin
      mem_ack <= 1'b0;
      cnt <= mem_req.req ? cnt + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : dlh_host_mem
`default_nettype wire

// file: test/dlh_properties.sv
// Port checker for the descriptor list handler
`timescale 1ns/1ps
`default_nettype none
module dlh_properties
  import dlh_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Memory, fragment and interrupt
  input wire dlh_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire dlh_frag_t frag,
  input wire logic frag_done,
  input wire dlh_frag_result_t frag_result,
  input wire logic irq
);
  logic [1:0] ri;
  logic [31:0] cw, bw;
  logic lrx, llast, rack, wreq;
  assign rack = mem_ack && !mem_req.we;
  assign wreq = mem_req.req && mem_req.we;
  // Last fetched cmdsts and pointer words
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ri <= 2'h0;
      cw <= 32'h0000_0000;
      bw <= 32'h0000_0000;
      lrx <= 1'b0;
      llast <= 1'b0;
    end else begin
      ri <= (!mem_req.req || frag.valid) ? 2'h0 : ri + {1'b0, rack};
      if (rack && ri == 2'h1) cw <= mem_rdata;
      if (rack && ri == 2'h2) bw <= mem_rdata;
      if (frag.valid) lrx <= frag.is_rx;
      if (frag_done) llast <= frag_result.last;
    end
  end
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  req_hold_a: assert property (
    mem_req.req && !mem_ack |=> $stable(mem_req))
    else $error("request moved before ack");
  buf_ptr_a: assert property (
    $rose(frag.valid) |-> frag.addr == (frag.is_rx ? {bw[31:2], 2'b00} : bw))
    else $error("fragment address wrong");
  tx_fields_a: assert property (
    $rose(frag.valid) && !frag.is_rx |->
    frag.omit_fcs_flag == cw[28] && frag.count == cw[15:0])
    else $error("transmit fragment fields wrong");
  owned_only_a: assert property (
    $rose(frag.valid) |-> cw[31] != frag.is_rx)
    else $error("fragment from unowned descriptor");
  rx_fcs_a: assert property (
    frag.valid && frag.is_rx |-> frag.fcs_included_flag)
    else $error("receive fcs flag clear");
  frag_end_a: assert property (
    frag.valid && frag_done |=>
    !frag.valid && wreq && mem_req.wdata[31] == lrx)
    else $error("write-back missing or owner wrong");
  rx_more_a: assert property (
    wreq && lrx |-> mem_req.wdata[30] == !llast && mem_req.wdata[28])
    else $error("receive write-back flags wrong");
  final_status_a: assert property (
    wreq && mem_req.wdata[30] |-> mem_req.wdata[27:16] == 12'h000)
    else $error("status in non-final descriptor");
  cover property ($rose(frag.valid) && frag.is_rx);
  cover property ($rose(frag.valid) && frag.omit_fcs_flag);
  cover property ($rose(irq));
endmodule : dlh_properties
bind dlh_descriptor_list_handler dlh_properties u_props (
  .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .mem_req, .mem_ack, .mem_rdata, .frag, .frag_done, .frag_result, .irq
);
`default_nettype wire

// file: test/tb_descriptor_list_handler.sv
// Self-checking bench for the descriptor list handler
`timescale 1ns/1ps
`default_nettype none
module tb_descriptor_list_handler import dlh_pkg::*;;
  logic sys_clk, rst_n, reg_wr, reg_rd, mem_ack, frag_done, irq;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_rdata;
  logic [31:0] cw [0:5];
  logic [31:0] fa [0:5];
  logic [1:0] lat;
  dlh_mem_req_t mem_req;
  dlh_frag_t frag;
  dlh_frag_result_t frag_result;
  dlh_frag_result_t res [0:5];
  int failures, check_count, nfrag, seed, i;
  dlh_descriptor_list_handler u_dut (
    .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .mem_req, .mem_ack, .mem_rdata, .frag, .frag_done, .frag_result, .irq
  );
  dlh_host_mem u_mem (
    .sys_clk, .rst_n, .mem_req, .lat, .mem_ack, .mem_rdata
  );
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Data path finishing fragments after random stalls
  always @(posedge sys_clk) begin
    if (frag.valid && !frag_done && $random(seed) % 2 == 0) begin
      frag_done <= 1'b1;
      frag_result <= res[nfrag];
      fa[nfrag] <= frag.addr;
      nfrag <= nfrag + 1;
    end else begin
      frag_done <= 1'b0;
    end
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic ic(input logic e);
    #1;
    chk("irq", irq, e);
    @(posedge sys_clk);
  endtask : ic
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge sys_clk);
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e, string n);
    logic [31:0] d;
    rd(a, d);
    chk(n, d, e);
  endtask : rc
  task automatic run_wait(input int b);
    logic [31:0] d;
    d = 32'hffff_ffff;
    for (int k = 0; k < 100 && d[b]; k++) rd(OFF_CTRL, d);
    chk("run bit", d[b], 1'b0);
  endtask : run_wait
  function automatic logic [31:0] wb(input logic rx, input logic [31:0] c,
                                     input dlh_frag_result_t r);
    logic m;
    m = rx ? !r.last : c[30];
    return {rx, m, c[29], rx | c[28], m ? 12'h000 : r.status,
            rx ? r.size : c[15:0]};
  endfunction : wb
  task automatic dchk(input int j0, input logic rx);
    for (int j = j0; j < j0 + 2; j++) begin
      chk("cmdsts", u_mem.mem[j*4+1], wb(rx, cw[j], res[j-rx]));
      chk("bufptr", fa[j-rx], u_mem.mem[j*4+2+rx]);
    end
    chk("unowned", u_mem.mem[j0*4+9], cw[j0+2]);
  endtask : dchk
  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    summarize();
  end
  initial begin
    seed = 32'h7ae1;
    {rst_n, reg_wr, reg_rd} = 3'h0;
    {reg_addr, reg_wdata, lat} = '0;
    {failures, check_count} = '0;
    // Three transmit then three receive descriptors
    for (i = 0; i < 6; i++) begin
      cw[i] = $random(seed);
      cw[i][31] = (i % 3 == 2) ^ (i < 3);
      cw[i][30] = (i % 3 == 0);
      cw[i][29] = cw[i][29] | (i % 3 == 0);
      res[i] = $random(seed);
      u_mem.mem[i*4] = (i + 1) * 16;
      u_mem.mem[i*4+1] = cw[i];
      u_mem.mem[i*4+2] = $random(seed);
      u_mem.mem[i*4+3] = $random(seed) & 32'hffff_fffc;
    end
    res[2].last = 1'b0;
    res[3].last = 1'b1;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (i = 0; i < 16; i++) rc(8'(i * 4), 32'(i == 1), "reset value");
    $display("test reset done");
    wr(OFF_IMR, 32'h0000_0001);
    wr(OFF_TXDP, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0001);
    run_wait(0);
    dchk(0, 1'b0);
    chk("fragments", nfrag, 2);
    rc(OFF_TXDP, 32'h0000_0020, "tx pointer");
    rc(OFF_ISR, 32'h0000_0005, "status");
    ic(1'b1);
    wr(OFF_ISR, 32'h0000_0005);
    wr(OFF_IMR, 32'h0000_0002);
    ic(1'b0);
    $display("test transmit done");
    lat <= 2'h3;
    wr(OFF_RXDP, 32'h0000_0030);
    wr(OFF_CTRL, 32'h0000_0006);
    run_wait(1);
    dchk(3, 1'b1);
    chk("fragments", nfrag, 4);
    rc(OFF_RXDP, 32'h0000_0050, "rx pointer");
    ic(1'b1);
    wr(OFF_ISR, 32'h0000_0002);
    ic(1'b0);
    rc(OFF_ISR, 32'h0000_0008, "status");
    $display("test receive done");
    summarize();
  end
endmodule : tb_descriptor_list_handler
`default_nettype wire
